// file: ssbr_pkg.sv
// Package for the secondary supervision and blanking register bank
package ssbr_pkg;
    // Register indices on the message port
    localparam logic [6:0] ADDR_VERIFY = 7'h17;
    localparam logic [6:0] ADDR_DESATURATION_DETECT = 7'h18;
    localparam logic [6:0] ADDR_OCP = 7'h19;
    // Reset values
    localparam logic [15:0] RST_VERIFY = 16'h0001;
    localparam logic [15:0] RST_DESATURATION_DETECT = 16'h2000;
    localparam logic [15:0] RST_OCP = 16'h0001;
    // Field layout
    localparam int VFS_LSB = 4;
    localparam int VFS_MSB = 5;
    localparam int BT_LSB = 8;
    localparam int BT_MSB = 15;
    localparam int DISC_BIT = 1;
    localparam int PAR_BIT = 0;
    // Verification select codes
    localparam logic [1:0] VFS_NONE = 2'h0;
    localparam logic [1:0] VFS_TIMING = 2'h1;
    // Least useful blanking count
    localparam logic [7:0] BT_MIN = 8'h0a;
    localparam logic [7:0] BT_OFF = 8'h00;
    // Blanking state machine
    typedef enum logic [1:0] {
        BLK_IDLE = 2'h1,
        BLK_RUN = 2'h2
    } ssbr_blk_t;
endpackage : ssbr_pkg

// file: ssbr_blank.sv
// Blanking counter that masks one fault comparator after a gate edge
`timescale 1ns/1ps
module ssbr_blank #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic osc_tick_i,
    input wire logic gate_edge_i,
    input wire logic [W-1:0] count_i,
    input wire logic enable_i,
    input wire logic comp_i,
    output logic fault_o,
    output logic blanking_o
);
    ssbr_pkg::ssbr_blk_t state;
    logic [W-1:0] remain;

    // R11 mask after edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ssbr_pkg::BLK_IDLE;
            remain <= '0;
        end else begin
            case (state)
                ssbr_pkg::BLK_IDLE: begin
                    if (gate_edge_i && enable_i) begin
                        state <= ssbr_pkg::BLK_RUN;
                        remain <= count_i;
                    end
                end
                ssbr_pkg::BLK_RUN: begin
                    if (gate_edge_i) begin
                        remain <= count_i;
                    end else if (osc_tick_i) begin
                        if (remain <= W'(1)) begin
                            state <= ssbr_pkg::BLK_IDLE;
                        end
                        remain <= remain - W'(1);
                    end
                end
                default: state <= ssbr_pkg::BLK_IDLE;
            endcase
        end
    end

    // R11 evaluate outside window
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_o <= 1'b0;
        end else begin
            fault_o <= comp_i && (state == ssbr_pkg::BLK_IDLE)
                && !(gate_edge_i && enable_i);
        end
    end

    assign blanking_o = (state == ssbr_pkg::BLK_RUN);
endmodule : ssbr_blank

// file: ssbr_regs.sv
// Secondary supervision select and fault blanking register bank
// Operation
// R1 - Verification select code 0 enables nothing and code 1 the timing check.
// R2 - The host writes only codes 0 or 1 to the verification select field.
// R3 - The stored selection takes effect only on entry to verification mode.
// R4 - Entering startup mode clears the verification select field.
// R5 - Desaturation_detect blanking bits 15:8 count oscillator cycles; host programs >= 0xa.
// R6 - Overcurrent blanking count comes from bits 15:8 in oscillator cycles.
// R7 - An overcurrent blanking count of zero disables its blanking entirely; an open window runs on, and a gate edge in it blanks to the next tick.
// R8 - When used, the host programs overcurrent blanking >= 0xa.
// R9 - Bit 1 of each register shows whether the last message was discarded.
// R10 - Bit 0 of each read value is odd parity over the word.
// R11 - A fault comparator is ignored for the blanking count after a gate edge.
`timescale 1ns/1ps
module ssbr_regs #(
    parameter int BT_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Decoded message port
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [6:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic msg_done_i,
    input wire logic msg_discarded_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    // Operating mode entry pulses
    input wire logic startup_operating_mode_i,
    input wire logic verification_operating_mode_i,
    // Gate and comparators
    input wire logic secondary_oscillator_clock_i,
    input wire logic gate_edge_i,
    input wire logic desaturation_detect_i,
    input wire logic overcurrent_protect_i,
    output logic [1:0] verify_function_o,
    output logic timing_check_o,
    output logic desaturation_detect_fault_o,
    output logic overcurrent_fault_o,
    output logic desaturation_detect_blanking_o,
    output logic overcurrent_blanking_o
);
    ////////////////////////////////////////////////////////////////////////
    logic rst_sync1;
    logic rst_n;
    logic [1:0] verify_function_select;
    logic [BT_W-1:0] desaturation_detect_blank_count;
    logic [BT_W-1:0] overcurrent_blank_count;
    logic last_message_discarded;
    logic osc_q;
    logic osc_tick;
    logic [15:0] next_rdata;
    logic [15:0] raw;
    logic ocp_en;
    logic wr_verify;
    logic wr_desaturation_detect;
    logic wr_ocp;

    // Reset is released through two flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_sync1 <= 1'b1;
            rst_n <= rst_sync1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One strobe per mapped index; other indices write nothing
    assign wr_verify = wr_en_i && (addr_i == ssbr_pkg::ADDR_VERIFY);
    assign wr_desaturation_detect = wr_en_i && (addr_i == ssbr_pkg::ADDR_DESATURATION_DETECT);
    assign wr_ocp = wr_en_i && (addr_i == ssbr_pkg::ADDR_OCP);

    ////////////////////////////////////////////////////////////////////////
    // Verification select; mode clear beats a same-cycle write
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            verify_function_select <=
                ssbr_pkg::RST_VERIFY[ssbr_pkg::VFS_MSB:ssbr_pkg::VFS_LSB];
        // R4 clear on startup
        end else if (startup_operating_mode_i) begin
            verify_function_select <= ssbr_pkg::VFS_NONE;
        // Reserved codes are stored as written; host keeps to 0 and 1
        end else if (wr_verify) begin
            // R2 host writes legal codes
            verify_function_select <=
                wdata_i[ssbr_pkg::VFS_MSB:ssbr_pkg::VFS_LSB];
        end
    end

    // R3 latch on verify entry
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            verify_function_o <= ssbr_pkg::VFS_NONE;
        end else if (verification_operating_mode_i) begin
            verify_function_o <= verify_function_select;
        end
    end

    // R1 decode select code
    assign timing_check_o = (verify_function_o == ssbr_pkg::VFS_TIMING);

    ////////////////////////////////////////////////////////////////////////
    // Blanking counts; minimum of 0xa is left to the host
    // Zero desaturation_detect count still blanks one tick, so the host must not use it
    // R5 desaturation_detect count field
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            desaturation_detect_blank_count <=
                ssbr_pkg::RST_DESATURATION_DETECT[ssbr_pkg::BT_MSB:ssbr_pkg::BT_LSB];
        end else if (wr_desaturation_detect) begin
            desaturation_detect_blank_count <=
                wdata_i[ssbr_pkg::BT_MSB:ssbr_pkg::BT_LSB];
        end
    end

    // R6 overcurrent count field
    // R8 host keeps count legal
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            overcurrent_blank_count <=
                ssbr_pkg::RST_OCP[ssbr_pkg::BT_MSB:ssbr_pkg::BT_LSB];
        end else if (wr_ocp) begin
            overcurrent_blank_count <=
                wdata_i[ssbr_pkg::BT_MSB:ssbr_pkg::BT_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // R9 track discarded message
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            last_message_discarded <= 1'b0;
        end else if (msg_done_i) begin
            last_message_discarded <= msg_discarded_i;
        end
    end

    // Oscillator is sampled as a plain synchronous input
    // Free-running, so a tick may land just after reset; no window is open
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= secondary_oscillator_clock_i;
        end
    end
    assign osc_tick = secondary_oscillator_clock_i && !osc_q;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        raw = '0;
        case (addr_i)
            ssbr_pkg::ADDR_VERIFY: begin
                raw[ssbr_pkg::VFS_MSB:ssbr_pkg::VFS_LSB] =
                    verify_function_select;
            end
            ssbr_pkg::ADDR_DESATURATION_DETECT: begin
                raw[ssbr_pkg::BT_MSB:ssbr_pkg::BT_LSB] = desaturation_detect_blank_count;
            end
            ssbr_pkg::ADDR_OCP: begin
                raw[ssbr_pkg::BT_MSB:ssbr_pkg::BT_LSB] =
                    overcurrent_blank_count;
            end
            default: raw = '0;
        endcase
        // R9 discard flag bit
        raw[ssbr_pkg::DISC_BIT] = last_message_discarded;
        next_rdata = raw;
        // R10 odd parity bit
        next_rdata[ssbr_pkg::PAR_BIT] = ~(^raw[15:1]);
    end

    // Read answer strobe, one cycle after the request
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_en_i;
        end
    end

    // Read word holds until the next read
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= '0;
        end else if (rd_en_i) begin
            rdata_o <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // R7 zero count stops a new window from opening; an open one runs on
    assign ocp_en = (overcurrent_blank_count != ssbr_pkg::BT_OFF);

    // R11 desaturation_detect blanking window
    // Both windows share one gate edge and one oscillator tick
    ssbr_blank #(.W(BT_W)) u_desaturation_detect (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .osc_tick_i(osc_tick),
        .gate_edge_i(gate_edge_i),
        .count_i(desaturation_detect_blank_count),
        .enable_i(1'b1),
        .comp_i(desaturation_detect_i),
        .fault_o(desaturation_detect_fault_o),
        .blanking_o(desaturation_detect_blanking_o)
    );

    // R11 overcurrent blanking window
    ssbr_blank #(.W(BT_W)) u_ocp (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .osc_tick_i(osc_tick),
        .gate_edge_i(gate_edge_i),
        .count_i(overcurrent_blank_count),
        .enable_i(ocp_en),
        .comp_i(overcurrent_protect_i),
        .fault_o(overcurrent_fault_o),
        .blanking_o(overcurrent_blanking_o)
    );
endmodule : ssbr_regs

// file: ssbr_regs_properties.sv
// Checker for the supervision and blanking register bank
`timescale 1ns/1ps
module ssbr_regs_properties (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [6:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic gate_edge_i,
    input wire logic verification_operating_mode_i,
    input wire logic [15:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic [1:0] verify_function_o,
    input wire logic timing_check_o,
    input wire logic desaturation_detect_fault_o,
    input wire logic overcurrent_fault_o,
    input wire logic desaturation_detect_blanking_o,
    input wire logic overcurrent_blanking_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////
    // Shadow of the overcurrent count, needed to tell disabled from used
    logic [7:0] ocp_cnt;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ocp_cnt <= 8'h00;
        end else if (wr_en_i && addr_i == ssbr_pkg::ADDR_OCP) begin
            ocp_cnt <= wdata_i[15:8];
        end
    end
    sequence s_answer;
        ##1 rvalid_o;
    endsequence
    sequence s_blank_d;
        ##1 desaturation_detect_blanking_o;
    endsequence
    ////////////////////////////////////////////////////////////////////
    AST_TIMING: assert property (
        timing_check_o == (verify_function_o == 2'h1))
        else $error("timing check decode wrong");
    AST_RVALID: assert property (
        rd_en_i |-> s_answer)
        else $error("no read answer");
    AST_PARITY: assert property (
        rvalid_o |-> ^rdata_o)
        else $error("read word parity even");
    AST_RSVD: assert property (
        rvalid_o |-> rdata_o[7:6] == 2'h0 && rdata_o[3:2] == 2'h0)
        else $error("reserved bits set");
    AST_HOLD: assert property (
        !verification_operating_mode_i |=> $stable(verify_function_o))
        else $error("selection moved outside entry");
    AST_DBLANK: assert property (
        gate_edge_i |-> s_blank_d)
        else $error("desaturation_detect blanking missing");
    AST_OBLANK: assert property (
        gate_edge_i && ocp_cnt != 8'h00 |=> overcurrent_blanking_o)
        else $error("ocp blanking missing");
    AST_OOFF: assert property (
        gate_edge_i && ocp_cnt == 8'h00 && !overcurrent_blanking_o
        |=> !overcurrent_blanking_o)
        else $error("ocp blanking not off");
    AST_MASK: assert property (
        desaturation_detect_blanking_o |-> !desaturation_detect_fault_o)
        else $error("fault during blanking");
    AST_OMASK: assert property (
        overcurrent_blanking_o |-> !overcurrent_fault_o)
        else $error("fault during ocp blanking");
endmodule : ssbr_regs_properties

// file: ssbr_host.sv
// Host model driving the register message port
`timescale 1ns/1ps
module ssbr_host (
    input wire logic clk_i,
    input wire logic rvalid_i,
    input wire logic [15:0] rdata_i,
    output logic wr_en_o,
    output logic rd_en_o,
    output logic [6:0] addr_o,
    output logic [15:0] wdata_o
);
    initial begin
        {wr_en_o, rd_en_o, addr_o, wdata_o} = 25'h0;
    end
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk_i);
        {wr_en_o, addr_o, wdata_o} <= {1'b1, a, d};
        @(posedge clk_i);
        // Released lines show junk, not the last value
        {wr_en_o, addr_o, wdata_o} <= {1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(posedge clk_i);
        {rd_en_o, addr_o} <= {1'b1, a};
        @(posedge clk_i);
        {rd_en_o, addr_o} <= {1'b0, ~a};
        @(posedge clk_i);
        d = rvalid_i ? rdata_i : 16'hxxxx;
    endtask : rd
endmodule : ssbr_host

// file: tb_secondary_supervision_blanking_regs.sv
// Testbench for the supervision and blanking register bank
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_secondary_supervision_blanking_regs;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic msg_done, msg_disc, smode, vmode, gate, comp, wr_en, rd_en;
    logic [1:0] div = 2'h0;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [6:0] addr;
    logic [15:0] wdata, rdata;
    logic [1:0] vf;
    logic rvalid, tchk, dfault, ofault, dblank, oblank;
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // Oscillator rises once every four clocks
    always @(posedge clk_i) begin
        div <= div + 2'h1;
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end
    ssbr_regs dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en),
        .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata),
        .msg_done_i(msg_done), .msg_discarded_i(msg_disc),
        .rdata_o(rdata), .rvalid_o(rvalid), .startup_operating_mode_i(smode),
        .verification_operating_mode_i(vmode),
        .secondary_oscillator_clock_i(div[1]), .gate_edge_i(gate),
        .desaturation_detect_i(comp), .overcurrent_protect_i(comp),
        .verify_function_o(vf), .timing_check_o(tchk),
        .desaturation_detect_fault_o(dfault), .overcurrent_fault_o(ofault),
        .desaturation_detect_blanking_o(dblank), .overcurrent_blanking_o(oblank));
    ssbr_host host_u (.clk_i(clk_i), .rvalid_i(rvalid), .rdata_i(rdata),
        .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));
    task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
        logic [15:0] d;
        host_u.rd(a, d);
        `CHK("read word", e, d)
    endtask : rdchk
    task automatic pulse(input logic v, input logic s);
        @(posedge clk_i);
        {vmode, smode, msg_done} <= {v, s, !(v | s)};
        @(posedge clk_i);
        {vmode, smode, msg_done} <= 3'h0;
        @(posedge clk_i);
    endtask : pulse
    task automatic gate_run(input logic d, output int c);
        c = 0;
        gate <= 1'b1;
        @(posedge clk_i);
        gate <= 1'b0;
        @(posedge clk_i);
        while ((d ? dblank : oblank) === 1'b1 && c < 300) begin
            @(posedge clk_i);
            c++;
        end
    endtask : gate_run
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdchk(ssbr_pkg::ADDR_VERIFY, 16'h0001);
        rdchk(ssbr_pkg::ADDR_DESATURATION_DETECT, 16'h2000);
        rdchk(ssbr_pkg::ADDR_OCP, 16'h0001);
    endtask : t_reset
    task automatic t_regs;
        host_u.wr(ssbr_pkg::ADDR_DESATURATION_DETECT, 16'h0bff);
        host_u.wr(ssbr_pkg::ADDR_OCP, 16'h0c00);
        host_u.wr(7'h1a, 16'h5500);
        rdchk(ssbr_pkg::ADDR_DESATURATION_DETECT, 16'h0b00);
        rdchk(ssbr_pkg::ADDR_OCP, 16'h0c01);
        rdchk(7'h1a, 16'h0001);
    endtask : t_regs
    task automatic t_discard;
        msg_disc <= 1'b1;
        pulse(1'b0, 1'b0);
        rdchk(ssbr_pkg::ADDR_OCP, 16'h0c02);
        msg_disc <= 1'b0;
        pulse(1'b0, 1'b0);
        rdchk(ssbr_pkg::ADDR_DESATURATION_DETECT, 16'h0b00);
    endtask : t_discard
    task automatic t_mode;
        host_u.wr(ssbr_pkg::ADDR_VERIFY, 16'h0010);
        rdchk(ssbr_pkg::ADDR_VERIFY, 16'h0010);
        `CHK("select held", 2'h0, vf)
        pulse(1'b1, 1'b0);
        `CHK("timing check", 1'b1, tchk)
        pulse(1'b0, 1'b1);
        rdchk(ssbr_pkg::ADDR_VERIFY, 16'h0001);
        pulse(1'b1, 1'b0);
        `CHK("select none", 2'h0, vf)
    endtask : t_mode
    task automatic t_blank;
        int c;
        host_u.wr(ssbr_pkg::ADDR_DESATURATION_DETECT, 16'h0a00);
        comp <= 1'b1;
        gate_run(1'b1, c);
        `CHK("desaturation_detect window", 1'b1, c >= 36 && c <= 44)
        repeat (2) @(posedge clk_i);
        `CHK("fault resumes", 1'b1, dfault)
        gate_run(1'b0, c);
        `CHK("ocp window", 1'b1, c >= 44 && c <= 52)
        repeat (2) @(posedge clk_i);
        `CHK("ocp fault resumes", 1'b1, ofault)
        host_u.wr(ssbr_pkg::ADDR_OCP, 16'h0000);
        gate_run(1'b0, c);
        `CHK("ocp off", 0, c)
        `CHK("ocp unmasked", 1'b1, ofault)
        comp <= 1'b0;
    endtask : t_blank
    task automatic results;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    initial begin
        {msg_done, msg_disc, smode, vmode, gate, comp} = 6'h00;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_reset();
        t_regs();
        t_discard();
        t_mode();
        t_blank();
        results();
    end
endmodule : tb_secondary_supervision_blanking_regs
bind ssbr_regs ssbr_regs_properties chk_u (.clk_i, .rst_n_i, .wr_en_i,
    .rd_en_i, .addr_i, .wdata_i, .gate_edge_i,
    .verification_operating_mode_i, .rdata_o, .rvalid_o, .verify_function_o,
    .timing_check_o, .desaturation_detect_fault_o, .overcurrent_fault_o,
    .desaturation_detect_blanking_o,
    .overcurrent_blanking_o);
